// [logic/fault_clip_params.svh]
// constants for the fault status and clipper register bank
`ifndef FAULT_CLIP_PARAMS_SVH
`define FAULT_CLIP_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_FAULT_STATUS 8'h08
`define ADDR_RSVD_FIRST 8'h09
`define ADDR_RSVD_LAST 8'h0F
`define ADDR_CLIP_MID 8'h10
`define ADDR_CLIP_LOW 8'h11

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define SCALE_MSB 5
`define SCALE_LSB 4
`define CLIP_LOW_MSB 7
`define CLIP_LOW_LSB 2
`define RST_FAULT_STATUS 8'h00
`define RST_CLIP_MID 8'h01
`define RST_CLIP_LOW 8'h04
`define CLIP_LEVEL_WIDTH 20

`endif

// [logic/fault_clip_pkg.sv]
// types shared by the fault status and clipper register bank
package fault_clip_pkg;

  typedef enum logic [1:0] {
    SCALE_FULL,
    SCALE_75,
    SCALE_50,
    SCALE_25
  } oc_scale_type;

  // raw fault detector levels from the analog side
  typedef struct packed {
    logic clock_error;
    logic overcurrent_raw;
    logic dc_offset_raw;
    logic overtemp_raw;
  } fault_in_type;

  // host register access
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

endpackage : fault_clip_pkg

// [logic/oc_trip_level.sv]
// overcurrent trip level scaling from the two-bit scale field
`timescale 1ns/10ps
`default_nettype none
module oc_trip_level
  import fault_clip_pkg::*;
#(
  parameter int LEVEL_WIDTH = 12
) (
  input wire logic [1:0] overcurrent_limit_scale_i,
  input wire logic [LEVEL_WIDTH-1:0] nominal_level_i,
  output logic [LEVEL_WIDTH-1:0] trip_level_o
);
  // ----------------------------------------
  // scale selection
  // ----------------------------------------
  wire logic [LEVEL_WIDTH-1:0] half_w = nominal_level_i >> 1;
  wire logic [LEVEL_WIDTH-1:0] quarter_w = nominal_level_i >> 2;
  wire oc_scale_type scale_w = oc_scale_type'(overcurrent_limit_scale_i);

  // shifts avoid a multiplier; 75% is half plus quarter
  always_comb begin
    unique case (scale_w)
      SCALE_FULL: trip_level_o = nominal_level_i;
      SCALE_75: trip_level_o = half_w + quarter_w;
      SCALE_50: trip_level_o = half_w;
      SCALE_25: trip_level_o = quarter_w;
    endcase
  end
endmodule : oc_trip_level
`default_nettype wire

// [logic/fault_latch.sv]
// one latching fault flag, cleared on entry to shutdown
`timescale 1ns/10ps
`default_nettype none
module fault_latch (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic event_i,
  input wire logic clear_i,
  output logic flag_o
);
  logic flag_reg;
  logic flag_next;

  // set wins over clear so an event in the clearing cycle stays visible
  assign flag_next = event_i | (flag_reg & ~clear_i);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_o = flag_reg;
endmodule : fault_latch
`default_nettype wire

// [logic/fault_status_clip_regs.sv]
// fault status, overcurrent scale and clip level register bank
`timescale 1ns/10ps
`default_nettype none
`include "fault_clip_params.svh"
module fault_status_clip_regs
  import fault_clip_pkg::*;
#(
  parameter int LEVEL_WIDTH = 12
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire reg_req_type req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  input wire logic speaker_shutdown_n_i,
  input wire logic shutdown_bit_i,
  input wire fault_in_type fault_i,
  input wire logic [LEVEL_WIDTH-1:0] current_level_i,
  input wire logic [LEVEL_WIDTH-1:0] nominal_level_i,
  input wire logic [5:0] clip_high_bits_i,
  output logic [`CLIP_LEVEL_WIDTH-1:0] clip_threshold_level_o,
  output logic [LEVEL_WIDTH-1:0] trip_level_o,
  output logic audio_run_o,
  output logic [3:0] fault_flags_o
);
  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic [1:0] scale_reg;
  logic [7:0] clip_mid_reg;
  logic [5:0] clip_low_reg;
  logic [1:0] clip_low_rsvd_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic shutdown_reg;
  logic clock_error_reg;

  // address decode
  wire logic hit_fault_w = req_i.addr == `ADDR_FAULT_STATUS;
  wire logic hit_mid_w = req_i.addr == `ADDR_CLIP_MID;
  wire logic hit_low_w = req_i.addr == `ADDR_CLIP_LOW;
  wire logic wr_fault_w = req_i.wr_en & hit_fault_w;
  wire logic wr_mid_w = req_i.wr_en & hit_mid_w;
  wire logic wr_low_w = req_i.wr_en & hit_low_w;

  // shutdown from pin low or host clearing its bit
  wire logic in_shutdown_w = ~speaker_shutdown_n_i | ~shutdown_bit_i;
  wire logic enter_sd_w = in_shutdown_w & ~shutdown_reg;

  // ----------------------------------------
  // overcurrent trip compare
  // ----------------------------------------
  oc_trip_level #(
    .LEVEL_WIDTH(LEVEL_WIDTH)
  ) u_trip (
    .overcurrent_limit_scale_i(scale_reg),
    .nominal_level_i(nominal_level_i),
    .trip_level_o(trip_level_o)
  );

  wire logic oc_event_w = fault_i.overcurrent_raw | (current_level_i > trip_level_o);

  // ----------------------------------------
  // latching faults
  // ----------------------------------------
  logic oc_flag;
  logic dc_flag;
  logic ot_flag;

  fault_latch u_oc (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .event_i(oc_event_w),
    .clear_i(enter_sd_w),
    .flag_o(oc_flag)
  );

  fault_latch u_dc (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .event_i(fault_i.dc_offset_raw),
    .clear_i(enter_sd_w),
    .flag_o(dc_flag)
  );

  fault_latch u_ot (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .event_i(fault_i.overtemp_raw),
    .clear_i(enter_sd_w),
    .flag_o(ot_flag)
  );

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // flags are not writable; only the scale field takes host data
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      scale_reg <= 2'(`RST_FAULT_STATUS >> `SCALE_LSB);
    end else if (wr_fault_w) begin
      scale_reg <= req_i.wdata[`SCALE_MSB:`SCALE_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      clip_mid_reg <= `RST_CLIP_MID;
    end else if (wr_mid_w) begin
      clip_mid_reg <= req_i.wdata;
    end
  end

  // reserved low bits store whatever the host writes; it is told to keep zero
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      clip_low_reg <= 6'(`RST_CLIP_LOW >> `CLIP_LOW_LSB);
      clip_low_rsvd_reg <= 2'(`RST_CLIP_LOW);
    end else if (wr_low_w) begin
      clip_low_reg <= req_i.wdata[`CLIP_LOW_MSB:`CLIP_LOW_LSB];
      clip_low_rsvd_reg <= req_i.wdata[1:0];
    end
  end

  // shutdown edge tracking and clock error level, both plain levels
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      shutdown_reg <= 1'b1;
      clock_error_reg <= 1'b0;
    end else begin
      shutdown_reg <= in_shutdown_w;
      clock_error_reg <= fault_i.clock_error;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // status image: reserved top bits read zero; unmapped and reserved reads give zero
  wire logic [7:0] status_w = {2'b00, scale_reg, clock_error_reg, oc_flag, dc_flag, ot_flag};
  wire logic [7:0] low_w = {clip_low_reg, clip_low_rsvd_reg};
  wire logic [7:0] rsel_w = hit_fault_w ? status_w :
                            hit_mid_w ? clip_mid_reg :
                            hit_low_w ? low_w : 8'h00;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= req_i.rd_en ? rsel_w : rdata_reg;
      rvalid_reg <= req_i.rd_en;
    end
  end

  assign rdata_o = rdata_reg;
  assign rvalid_o = rvalid_reg;

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign clip_threshold_level_o = {clip_high_bits_i, clip_mid_reg, clip_low_reg};
  assign fault_flags_o = status_w[3:0];
  // clock faults stop audio only while present; latched ones until toggle
  assign audio_run_o = ~shutdown_reg & ~clock_error_reg
                       & ~oc_flag & ~dc_flag & ~ot_flag;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence sd_enter_s;
    !shutdown_reg ##1 shutdown_reg;
  endsequence

  clock_flag_follows_a: assert property (fault_flags_o[3] == $past(fault_i.clock_error))
    else $error("clock flag does not follow clock error");
  clock_recover_a: assert property (
    $fell(clock_error_reg) && !shutdown_reg && !oc_flag && !dc_flag && !ot_flag
    |-> audio_run_o)
    else $error("audio not resumed after clock recovery");
  oc_set_halts_a: assert property (oc_event_w |=> oc_flag && !audio_run_o)
    else $error("overcurrent did not latch and halt");
  oc_hold_a: assert property (oc_flag && !enter_sd_w |=> oc_flag)
    else $error("overcurrent flag dropped without shutdown");
  dc_set_a: assert property (fault_i.dc_offset_raw |=> dc_flag ##0 !audio_run_o)
    else $error("dc fault did not latch");
  ot_hold_a: assert property (ot_flag && !enter_sd_w && !fault_i.overtemp_raw |=> ot_flag)
    else $error("overtemp flag dropped early");
  status_top_zero_a: assert property (!(rvalid_o && rdata_o[7:6] != 2'b00 && $past(hit_fault_w)))
    else $error("reserved status bits nonzero");
  clip_mid_write_a: assert property (wr_mid_w |=> clip_threshold_level_o[13:6] == $past(req_i.wdata))
    else $error("clip middle byte not written");
  clip_low_write_a: assert property (wr_low_w |=> clip_threshold_level_o[5:0] == $past(req_i.wdata[7:2]))
    else $error("clip low bits not written");
  clear_on_entry_a: assert property (sd_enter_s ##0 !$past(fault_i.dc_offset_raw) |-> !dc_flag)
    else $error("latched flag not cleared on shutdown entry");
  sd_no_run_a: assert property (in_shutdown_w |=> !audio_run_o)
    else $error("audio running in shutdown");
endmodule : fault_status_clip_regs
`default_nettype wire

// [testbench/host_model.sv]
// host processor model driving the register request port
`timescale 1ns/10ps
`default_nettype none
`include "fault_clip_params.svh"
module host_model
  import fault_clip_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output reg_req_type req_o
);
  initial req_o = '0;
  // one write; an idle edge follows so the strobe is never rewritten in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    // reserved bits of the low clip register always go out as zero
    if (a == `ADDR_CLIP_LOW) d[1:0] = 2'h0;
    req_o <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    req_o <= '0;
    @(posedge clk_i);
  endtask : wr
  // one read; answer taken 1 ns after the request edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    req_o <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    req_o <= '0;
    #1;
    v = rvalid_i;
    d = rdata_i;
    @(posedge clk_i);
  endtask : rd
  // only mapped addresses are ever used, never 0x09 to 0x0F
endmodule : host_model
`default_nettype wire

// [testbench/fault_status_clip_regs_tb.sv]
// self-checking bench for the fault status and clip level registers
`timescale 1ns/10ps
`default_nettype none
`include "fault_clip_params.svh"
module fault_status_clip_regs_tb;
  import fault_clip_pkg::*;
  logic clk_i, reset_n_i, pin_n, sd_bit, rv;
  reg_req_type req;
  fault_in_type fault;
  logic [11:0] cur, nom, trip;
  logic [5:0] hi;
  logic [7:0] rdata, d, m, l;
  logic [19:0] clip;
  logic [3:0] flags;
  logic run, rvalid;
  int seed = 32'h4ea5;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  fault_status_clip_regs #(.LEVEL_WIDTH(12)) u_fault_status_clip_regs (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
    .speaker_shutdown_n_i(pin_n), .shutdown_bit_i(sd_bit), .fault_i(fault),
    .current_level_i(cur), .nominal_level_i(nom), .clip_high_bits_i(hi),
    .clip_threshold_level_o(clip), .trip_level_o(trip), .audio_run_o(run),
    .fault_flags_o(flags));
  host_model u_host_model (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // hang guard: far above the roughly 150 cycles the tests need
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end
  function automatic logic [11:0] exp_trip(input logic [1:0] s, input logic [11:0] n);
    case (s)
      2'd0: return n;
      2'd1: return (n >> 1) + (n >> 2);
      2'd2: return n >> 1;
      default: return n >> 2;
    endcase
  endfunction : exp_trip
  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // read through the host and compare data, with rvalid checked high
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    u_host_model.rd(a, d, rv);
    chk("rvalid", 20'h1, {19'h0, rv});
    chk("rdata", {12'h0, e}, {12'h0, d});
  endtask : rd_chk
  task automatic conclude();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset_n_i = 1'b0;
    pin_n = 1'b1;
    sd_bit = 1'b1;
    fault = '0;
    cur = '0;
    nom = 12'($random(seed)) & 12'h7FF;
    hi = 6'($random(seed));
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    rd_chk(`ADDR_FAULT_STATUS, 8'h00);
    rd_chk(`ADDR_CLIP_MID, 8'h01);
    rd_chk(`ADDR_CLIP_LOW, 8'h04);
    chk("clip_reset", {hi, 8'h01, 6'h01}, clip);
    $display("test reset done");
    // every scale code, ending at full level; other bits must not stick
    for (int s = 3; s >= 0; s--) begin
      u_host_model.wr(`ADDR_FAULT_STATUS, {2'h3, 2'(s), 4'hF});
      rd_chk(`ADDR_FAULT_STATUS, {2'h0, 2'(s), 4'h0});
      chk("trip", {8'h0, exp_trip(2'(s), nom)}, {8'h0, trip});
    end
    $display("test scale done");
    for (int i = 0; i < 8; i++) begin
      m = (i == 0) ? 8'hFF : 8'($random(seed));
      l = (i == 0) ? 8'hFC : 8'($random(seed)) & 8'hFC;
      u_host_model.wr(`ADDR_CLIP_MID, m);
      u_host_model.wr(`ADDR_CLIP_LOW, l);
      rd_chk(`ADDR_CLIP_MID, m);
      rd_chk(`ADDR_CLIP_LOW, l);
      chk("clip", {hi, m, l[7:2]}, clip);
    end
    $display("test clip done");
    // latched faults: over-temperature, dc offset, overcurrent by level
    for (int i = 0; i < 3; i++) begin
      @(negedge clk_i);
      chk("run_before", 20'h1, {19'h0, run});
      @(posedge clk_i);
      if (i == 2) cur <= nom + 12'h1;
      else fault <= fault_in_type'(4'h1 << i);
      @(posedge clk_i);
      fault <= '0;
      cur <= '0;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      chk("flags_latched", {16'h0, 4'h1 << i}, {16'h0, flags});
      chk("run_halted", 20'h0, {19'h0, run});
      @(posedge clk_i);
      rd_chk(`ADDR_FAULT_STATUS, 8'h01 << i);
      // toggle alternates between the pin and the control bit
      if (i == 1) sd_bit <= 1'b0;
      else pin_n <= 1'b0;
      @(posedge clk_i);
      @(negedge clk_i);
      chk("flags_cleared", 20'h0, {16'h0, flags});
      @(posedge clk_i);
      pin_n <= 1'b1;
      sd_bit <= 1'b1;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk("run_resumed", 20'h1, {19'h0, run});
      @(posedge clk_i);
    end
    $display("test latched faults done");
    // clock error: visible only while present, recovery needs no toggle
    fault.clock_error <= 1'b1;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    chk("clock_flag", 20'h8, {16'h0, flags});
    @(posedge clk_i);
    fault.clock_error <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("clock_flag_gone", 20'h0, {16'h0, flags});
    chk("run_auto", 20'h1, {19'h0, run});
    $display("test clock error done");
    conclude();
  end
endmodule : fault_status_clip_regs_tb
`default_nettype wire
